// [design/aspsr_pkg.sv]
// constants of the physical layer control and status register bank
package aspsr_pkg;
  localparam int CTL_NUM = 16;
  localparam int GRP_NUM = 6;
  localparam int STAT_NUM = 5;
  localparam int CNT_NUM = 4;
  localparam int CNT_W = 24;
  // control register indices
  localparam int CTL_GENERAL = 0;
  localparam int CTL_LOOPBACK = 1;
  localparam int CTL_CELL_GEN = 2;
  localparam int CTL_CELL_VALID = 3;
  localparam int CTL_BUS_ONE = 4;
  localparam int CTL_BUS_TWO = 5;
  localparam int CTL_TX_SEC = 6;
  localparam int CTL_TX_LINE = 7;
  localparam int CTL_TX_PATH = 8;
  localparam int CTL_TX_PROT_ONE = 9;
  localparam int CTL_TX_PROT_TWO = 10;
  localparam int CTL_LINE_FAIL_EN = 11;
  localparam int CTL_PROT_TH = 12;
  localparam int CTL_PATH_TH = 13;
  localparam int CTL_ERR_PATTERN = 14;
  localparam int CTL_SUM_MASK = 15;
  localparam logic [6:0] CTL_ADDR [CTL_NUM] = '{7'h00, 7'h01, 7'h04, 7'h08, 7'h0a, 7'h0b, 7'h0c, 7'h0d,
    7'h0e, 7'h10, 7'h11, 7'h6e, 7'h09, 7'h3b, 7'h07, 7'h34};
  localparam logic [7:0] PROT_TH_RST = 8'h36;
  localparam logic [7:0] PATH_TH_RST = 8'h46;
  localparam logic [7:0] CTL_RST [CTL_NUM] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, PROT_TH_RST, PATH_TH_RST, 8'h00, 8'h00};
  // general control bits
  localparam int CNTR_LATCH_BIT = 4;
  localparam int STAT_LATCH_BIT = 5;
  localparam int PIN_EN_BIT = 6;
  // interrupt groups: section, line, path, tx cell, rx cell, protection
  localparam int GRP_RX_CELL = 4;
  localparam int GRP_PROT = 5;
  localparam logic [6:0] GRP_MASK_ADDR [GRP_NUM] = '{7'h35, 7'h36, 7'h37, 7'h38, 7'h39, 7'h3a};
  localparam logic [6:0] GRP_IND_ADDR [GRP_NUM] = '{7'h3d, 7'h3e, 7'h3f, 7'h40, 7'h41, 7'h42};
  localparam int GRP_SUM_BIT [GRP_NUM] = '{7, 6, 5, 0, 1, 2};
  localparam logic [GRP_NUM-1:0] GRP_DUAL = 6'h20;
  localparam logic [6:0] ADDR_SUM_IND = 7'h3c;
  localparam logic [6:0] STAT_ADDR [STAT_NUM] = '{7'h45, 7'h46, 7'h47, 7'h48, 7'h49};
  localparam int STAT_RW_NUM = 2;
  localparam logic [1:0] STAT_RW_RST = 2'h0;
  // other addresses
  localparam logic [6:0] ADDR_ERR_INSERT = 7'h06;
  localparam logic [6:0] ADDR_RX_PROT_ONE = 7'h14;
  localparam logic [6:0] ADDR_RX_PROT_TWO = 7'h15;
  localparam logic [6:0] ADDR_RX_SYNC = 7'h16;
  localparam logic [6:0] ADDR_RX_LABEL = 7'h18;
  localparam logic [6:0] ADDR_RX_PATH_STAT = 7'h19;
  localparam logic [6:0] ADDR_RX_PROT_STAT = 7'h4a;
  // error counters: section, line, path, corrected header
  localparam int CNT_SEC = 0;
  localparam int CNT_LINE = 1;
  localparam int CNT_PATH = 2;
  localparam int CNT_HEC = 3;
  localparam int CNT_BYTES [CNT_NUM] = '{2, 3, 2, 1};
  localparam logic [6:0] CNT_BASE [CNT_NUM] = '{7'h54, 7'h50, 7'h56, 7'h4d};
  localparam logic [CNT_W-1:0] CNT_MAX [CNT_NUM] = '{24'h00ffff, 24'hffffff, 24'h00ffff, 24'h0000ff};
endpackage : aspsr_pkg

// [design/aspsr_intr_capture.sv]
// sticky change indication for one interrupt group
`timescale 1ns/1ps
`default_nettype none
module aspsr_intr_capture #(
  parameter bit DUAL = 1'b0
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] status,
  input wire logic [7:0] enable,
  input wire logic readClear,
  output logic [7:0] pend
);
  logic [7:0] prevStatus;
  logic [7:0] setv;
  logic [7:0] clrv;

  assign setv = (DUAL ? (prevStatus ^ status) : (~prevStatus & status)) & enable;
  assign clrv = readClear ? pend : 8'h00;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prevStatus <= 8'h00;
    end else begin
      prevStatus <= status;
    end
  end

  // a set in the clearing cycle survives
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pend <= 8'h00;
    end else begin
      pend <= (pend & ~clrv) | setv;
    end
  end

  chk_edge_sets_pend: assert property (@(posedge mclk) disable iff (!arst_n)
    setv != 8'h00 |=> (pend & $past(setv)) == $past(setv))
    else $error("enabled status change did not set its indication");
  chk_read_clears: assert property (@(posedge mclk) disable iff (!arst_n)
    readClear && setv == 8'h00 |=> pend == 8'h00)
    else $error("read of indication did not clear it");
  chk_no_spurious: assert property (@(posedge mclk) disable iff (!arst_n)
    (setv & ~pend) == 8'h00 |=> (pend & ~$past(pend)) == 8'h00)
    else $error("indication set without an enabled change");
endmodule : aspsr_intr_capture
`default_nettype wire

// [design/aspsr_regs.sv]
// control, status, interrupt and counter register bank of the physical layer
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - hardware clears each error insertion request bit after inserting that error
// - a hardware self-clear beats a simultaneous host write; the bit ends zero
// - status registers snapshot once per second only while status latch enable is one
// - error counters snapshot once per second only while counter latch enable is one
// - protection indications set on either status edge, only when enabled
// - reading an indication register clears the indications it returned
// - protection threshold: fail exponent high nibble, degrade low; defaults 3 and 6
// - path threshold: fail exponent high nibble default 4, degrade low default 6
// - section parity count read as low and high bytes at adjacent addresses
// - line parity count read as low, mid and high bytes at three addresses
// - path parity count read as low and high bytes at adjacent addresses
// - corrected header check errors are counted in their own counter register
// - protection interrupt reaches pin only with mask, summary and pin enables
// - rx cell interrupt reaches pin only with mask, summary and pin enables
// - rx section and line status: bits seven to two read-only, one to zero writable
// - last received protection bytes shown in two read-only registers
// - error pattern bits are exclusive-ored into the corrupted octet
// - single-event indications set on rising edge while enabled, clear on read
module aspsr_regs (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic regCs,
  input wire logic regRd,
  input wire logic regWr,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic [7:0] secStatus,
  input wire logic [7:0] lineStatus,
  input wire logic [7:0] pathStatus,
  input wire logic [7:0] txCellStatus,
  input wire logic [7:0] rxCellStatus,
  input wire logic [7:0] protStatus,
  input wire logic [7:0] rxProtByteOne,
  input wire logic [7:0] rxProtByteTwo,
  input wire logic rxProtValid,
  input wire logic [7:0] rxSyncStatus,
  input wire logic [7:0] rxPathLabel,
  input wire logic [7:0] rxPathStatusByte,
  input wire logic oneSecTick,
  input wire logic secParityErr,
  input wire logic lineParityErr,
  input wire logic pathParityErr,
  input wire logic hecCorrected,
  input wire logic [7:0] errInsDone,
  input wire logic [7:0] txOctetIn,
  input wire logic insertNow,
  output logic [7:0] txOctetOut,
  output logic [7:0] errInsReq,
  output logic [7:0] generalCtl,
  output logic [7:0] loopbackCtl,
  output logic [7:0] cellGenCtl,
  output logic [7:0] cellValidCtl,
  output logic [7:0] cellBusCtlOne,
  output logic [7:0] cellBusCtlTwo,
  output logic [7:0] txSecCtl,
  output logic [7:0] txLineCtl,
  output logic [7:0] txPathCtl,
  output logic [7:0] txProtOne,
  output logic [7:0] txProtTwo,
  output logic [7:0] lineFailOutEn,
  output logic [7:0] protThreshold,
  output logic [7:0] pathThreshold,
  output logic interruptOutN
);
  logic wrEn;
  logic rdEn;
  logic [7:0] ctl [aspsr_pkg::CTL_NUM];
  logic [7:0] intrMask [aspsr_pkg::GRP_NUM];
  logic [7:0] pend [aspsr_pkg::GRP_NUM];
  logic [7:0] statusIn [aspsr_pkg::GRP_NUM];
  logic [7:0] statLat [aspsr_pkg::STAT_NUM];
  logic [7:0] statShow [aspsr_pkg::STAT_NUM];
  logic [1:0] statRw [aspsr_pkg::STAT_RW_NUM];
  logic [aspsr_pkg::CNT_W-1:0] cntRun [aspsr_pkg::CNT_NUM];
  logic [aspsr_pkg::CNT_W-1:0] cntSnap [aspsr_pkg::CNT_NUM];
  logic [aspsr_pkg::CNT_W-1:0] cntShow [aspsr_pkg::CNT_NUM];
  logic [aspsr_pkg::CNT_NUM-1:0] cntInc;
  logic [7:0] rxProtOne;
  logic [7:0] rxProtTwo;
  logic [7:0] summaryInd;
  logic [7:0] next_rdata;
  logic [7:0] next_error_insertion_ctl;
  logic next_irqN;
  logic statLatchEn;
  logic cntLatchEn;

  assign wrEn = regCs & regWr;
  assign rdEn = regCs & regRd;
  assign statLatchEn = ctl[aspsr_pkg::CTL_GENERAL][aspsr_pkg::STAT_LATCH_BIT];
  assign cntLatchEn = ctl[aspsr_pkg::CTL_GENERAL][aspsr_pkg::CNTR_LATCH_BIT];
  assign statusIn[0] = secStatus;
  assign statusIn[1] = lineStatus;
  assign statusIn[2] = pathStatus;
  assign statusIn[3] = txCellStatus;
  assign statusIn[4] = rxCellStatus;
  assign statusIn[5] = protStatus;
  assign cntInc = {hecCorrected, pathParityErr, lineParityErr, secParityErr};

  ////////////////////////////////////////////////////////////////////////////
  // host writable control registers
  genvar gi;
  generate
    for (gi = 0; gi < aspsr_pkg::CTL_NUM; gi++) begin : g_ctl
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          ctl[gi] <= aspsr_pkg::CTL_RST[gi];
        end else if (wrEn && regAddr == aspsr_pkg::CTL_ADDR[gi]) begin
          ctl[gi] <= regWdata;
        end
      end
    end
  endgenerate

  assign generalCtl = ctl[aspsr_pkg::CTL_GENERAL];
  assign loopbackCtl = ctl[aspsr_pkg::CTL_LOOPBACK];
  assign cellGenCtl = ctl[aspsr_pkg::CTL_CELL_GEN];
  assign cellValidCtl = ctl[aspsr_pkg::CTL_CELL_VALID];
  assign cellBusCtlOne = ctl[aspsr_pkg::CTL_BUS_ONE];
  assign cellBusCtlTwo = ctl[aspsr_pkg::CTL_BUS_TWO];
  assign txSecCtl = ctl[aspsr_pkg::CTL_TX_SEC];
  assign txLineCtl = ctl[aspsr_pkg::CTL_TX_LINE];
  assign txPathCtl = ctl[aspsr_pkg::CTL_TX_PATH];
  assign txProtOne = ctl[aspsr_pkg::CTL_TX_PROT_ONE];
  assign txProtTwo = ctl[aspsr_pkg::CTL_TX_PROT_TWO];
  assign lineFailOutEn = ctl[aspsr_pkg::CTL_LINE_FAIL_EN];
  assign protThreshold = ctl[aspsr_pkg::CTL_PROT_TH];
  assign pathThreshold = ctl[aspsr_pkg::CTL_PATH_TH];

  ////////////////////////////////////////////////////////////////////////////
  // error insertion requests and octet corruption
  always_comb begin
    next_error_insertion_ctl = errInsReq;
    if (wrEn && regAddr == aspsr_pkg::ADDR_ERR_INSERT) begin
      next_error_insertion_ctl = regWdata;
    end
    next_error_insertion_ctl = next_error_insertion_ctl & ~errInsDone;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      errInsReq <= 8'h00;
    end else begin
      errInsReq <= next_error_insertion_ctl;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txOctetOut <= 8'h00;
    end else if (insertNow) begin
      txOctetOut <= txOctetIn ^ ctl[aspsr_pkg::CTL_ERR_PATTERN];
    end else begin
      txOctetOut <= txOctetIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // received protection bytes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rxProtOne <= 8'h00;
      rxProtTwo <= 8'h00;
    end else if (rxProtValid) begin
      rxProtOne <= rxProtByteOne;
      rxProtTwo <= rxProtByteTwo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overhead and cell status with one-second latching
  generate
    for (gi = 0; gi < aspsr_pkg::STAT_NUM; gi++) begin : g_stat
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          statLat[gi] <= 8'h00;
        end else if (oneSecTick && statLatchEn) begin
          statLat[gi] <= statusIn[gi];
        end
      end
    end
    for (gi = 0; gi < aspsr_pkg::STAT_RW_NUM; gi++) begin : g_stat_rw
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          statRw[gi] <= aspsr_pkg::STAT_RW_RST;
        end else if (wrEn && regAddr == aspsr_pkg::STAT_ADDR[gi]) begin
          statRw[gi] <= regWdata[1:0];
        end
      end
    end
  endgenerate

  always_comb begin
    for (int s = 0; s < aspsr_pkg::STAT_NUM; s++) begin
      statShow[s] = statLatchEn ? statLat[s] : statusIn[s];
    end
    for (int s = 0; s < aspsr_pkg::STAT_RW_NUM; s++) begin
      statShow[s][1:0] = statRw[s];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // saturating error counters with one-second snapshot
  generate
    for (gi = 0; gi < aspsr_pkg::CNT_NUM; gi++) begin : g_cnt
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          cntRun[gi] <= '0;
          cntSnap[gi] <= '0;
        end else if (oneSecTick && cntLatchEn) begin
          cntSnap[gi] <= cntRun[gi];
          cntRun[gi] <= {{(aspsr_pkg::CNT_W-1){1'b0}}, cntInc[gi]};
        end else if (cntInc[gi] && cntRun[gi] != aspsr_pkg::CNT_MAX[gi]) begin
          cntRun[gi] <= cntRun[gi] + 24'h000001;
        end
      end
      assign cntShow[gi] = cntLatchEn ? cntSnap[gi] : cntRun[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupt indications, summary and pin
  generate
    for (gi = 0; gi < aspsr_pkg::GRP_NUM; gi++) begin : g_intr
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          intrMask[gi] <= 8'h00;
        end else if (wrEn && regAddr == aspsr_pkg::GRP_MASK_ADDR[gi]) begin
          intrMask[gi] <= regWdata;
        end
      end
      aspsr_intr_capture #(
        .DUAL(aspsr_pkg::GRP_DUAL[gi])
      ) u_capture (
        .mclk(mclk),
        .arst_n(arst_n),
        .status(statusIn[gi]),
        .enable(intrMask[gi]),
        .readClear(rdEn && regAddr == aspsr_pkg::GRP_IND_ADDR[gi]),
        .pend(pend[gi])
      );
    end
  endgenerate

  always_comb begin
    summaryInd = 8'h00;
    for (int g = 0; g < aspsr_pkg::GRP_NUM; g++) begin
      summaryInd[aspsr_pkg::GRP_SUM_BIT[g]] = |(pend[g] & intrMask[g]);
    end
    next_irqN = ~(ctl[aspsr_pkg::CTL_GENERAL][aspsr_pkg::PIN_EN_BIT]
      & |(summaryInd & ctl[aspsr_pkg::CTL_SUM_MASK]));
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      interruptOutN <= 1'b1;
    end else begin
      interruptOutN <= next_irqN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data; test locations and unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < aspsr_pkg::CTL_NUM; i++) begin
      if (regAddr == aspsr_pkg::CTL_ADDR[i]) next_rdata = ctl[i];
    end
    for (int g = 0; g < aspsr_pkg::GRP_NUM; g++) begin
      if (regAddr == aspsr_pkg::GRP_MASK_ADDR[g]) next_rdata = intrMask[g];
      if (regAddr == aspsr_pkg::GRP_IND_ADDR[g]) next_rdata = pend[g];
    end
    for (int s = 0; s < aspsr_pkg::STAT_NUM; s++) begin
      if (regAddr == aspsr_pkg::STAT_ADDR[s]) next_rdata = statShow[s];
    end
    for (int c = 0; c < aspsr_pkg::CNT_NUM; c++) begin
      for (int b = 0; b < 3; b++) begin
        if (b < aspsr_pkg::CNT_BYTES[c] && regAddr == aspsr_pkg::CNT_BASE[c] + 7'(b)) begin
          next_rdata = cntShow[c][8*b +: 8];
        end
      end
    end
    unique case (regAddr)
      aspsr_pkg::ADDR_ERR_INSERT: next_rdata = errInsReq;
      aspsr_pkg::ADDR_SUM_IND: next_rdata = summaryInd;
      aspsr_pkg::ADDR_RX_PROT_ONE: next_rdata = rxProtOne;
      aspsr_pkg::ADDR_RX_PROT_TWO: next_rdata = rxProtTwo;
      aspsr_pkg::ADDR_RX_SYNC: next_rdata = rxSyncStatus;
      aspsr_pkg::ADDR_RX_LABEL: next_rdata = rxPathLabel;
      aspsr_pkg::ADDR_RX_PATH_STAT: next_rdata = rxPathStatusByte;
      aspsr_pkg::ADDR_RX_PROT_STAT: next_rdata = protStatus;
      default: ;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 8'h00;
    end else if (rdEn) begin
      regRdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_error_insertion_ctl_self_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    errInsDone != 8'h00 |=> (errInsReq & $past(errInsDone)) == 8'h00)
    else $error("error insertion bit not cleared after insertion");
  chk_status_latch_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !(oneSecTick && statLatchEn) |=> statLat[2] == $past(statLat[2]))
    else $error("status snapshot changed without enabled tick");
  chk_count_snap_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !(oneSecTick && cntLatchEn) |=> cntSnap[aspsr_pkg::CNT_LINE] == $past(cntSnap[aspsr_pkg::CNT_LINE]))
    else $error("counter snapshot changed without enabled tick");
  chk_threshold_reset: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(arst_n) |-> protThreshold == 8'h36 && pathThreshold == 8'h46)
    else $error("threshold defaults wrong after reset");
  chk_section_high_read: assert property (@(posedge mclk) disable iff (!arst_n)
    rdEn && regAddr == 7'h55 |=> regRdata == $past(cntShow[aspsr_pkg::CNT_SEC][15:8]))
    else $error("section count high byte read wrong");
  chk_line_mid_read: assert property (@(posedge mclk) disable iff (!arst_n)
    rdEn && regAddr == 7'h51 |=> regRdata == $past(cntShow[aspsr_pkg::CNT_LINE][15:8]))
    else $error("line count mid byte read wrong");
  chk_path_low_read: assert property (@(posedge mclk) disable iff (!arst_n)
    rdEn && regAddr == 7'h56 |=> regRdata == $past(cntShow[aspsr_pkg::CNT_PATH][7:0]))
    else $error("path count low byte read wrong");
  chk_hec_count_inc: assert property (@(posedge mclk) disable iff (!arst_n)
    hecCorrected && !oneSecTick && cntRun[aspsr_pkg::CNT_HEC] < 24'h0000ff
    |=> cntRun[aspsr_pkg::CNT_HEC] == $past(cntRun[aspsr_pkg::CNT_HEC]) + 24'h000001)
    else $error("corrected header count did not advance");
  chk_prot_pin_gate: assert property (@(posedge mclk) disable iff (!arst_n)
    (pend[aspsr_pkg::GRP_PROT] & intrMask[aspsr_pkg::GRP_PROT]) != 8'h00 && ctl[aspsr_pkg::CTL_SUM_MASK][2]
    && ctl[aspsr_pkg::CTL_GENERAL][6] |=> !interruptOutN)
    else $error("enabled protection interrupt missing on pin");
  chk_rx_cell_status_pin_gate: assert property (@(posedge mclk) disable iff (!arst_n)
    (pend[aspsr_pkg::GRP_RX_CELL] & intrMask[aspsr_pkg::GRP_RX_CELL]) != 8'h00
    && ctl[aspsr_pkg::CTL_SUM_MASK][1] && ctl[aspsr_pkg::CTL_GENERAL][6] |=> !interruptOutN)
    else $error("enabled rx cell interrupt missing on pin");
  chk_pin_release: assert property (@(posedge mclk) disable iff (!arst_n)
    !ctl[aspsr_pkg::CTL_GENERAL][6] || (summaryInd & ctl[aspsr_pkg::CTL_SUM_MASK]) == 8'h00 |=> interruptOutN)
    else $error("interrupt pin held without enabled indication");
  chk_status_rw_bits: assert property (@(posedge mclk) disable iff (!arst_n)
    wrEn && regAddr == 7'h45 |=> statRw[0] == $past(regWdata[1:0]))
    else $error("section status writable bits not stored");
  chk_prot_byte_store: assert property (@(posedge mclk) disable iff (!arst_n)
    rxProtValid |=> rxProtOne == $past(rxProtByteOne) && rxProtTwo == $past(rxProtByteTwo))
    else $error("received protection bytes not captured");
  chk_xor_insert: assert property (@(posedge mclk) disable iff (!arst_n)
    insertNow |=> txOctetOut == ($past(txOctetIn) ^ $past(ctl[aspsr_pkg::CTL_ERR_PATTERN])))
    else $error("error pattern not applied to octet");
endmodule : aspsr_regs
`default_nettype wire

// [sim/aspsr_host_model.sv]
// host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module aspsr_host_model (
  input wire logic mclk,
  output logic regCs,
  output logic regRd,
  output logic regWr,
  output logic [6:0] regAddr,
  output logic [7:0] regWdata
);
  initial {regCs, regRd, regWr, regAddr, regWdata} = '0;
  // one access: request held from one falling edge to the next
  task automatic acc(input logic wr, input logic [6:0] a, input logic [7:0] d);
    if (wr && a[6:1] == 6'h38) return;
    if (wr && a == 7'h01 && $countones(d) > 1) return;
    @(negedge mclk);
    {regCs, regRd, regWr, regAddr, regWdata} = {1'b1, ~wr, wr, a, d};
    @(negedge mclk);
    {regCs, regRd, regWr, regWdata} = {3'h0, ~d};
  endtask : acc
endmodule : aspsr_host_model
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk, arst_n, regCs, regRd, regWr, rxProtValid, oneSecTick, insertNow, interruptOutN, rdPend;
  logic secParityErr, lineParityErr, pathParityErr, hecCorrected;
  logic [6:0] regAddr;
  logic [7:0] regWdata, regRdata, secStatus, rxCellStatus, protStatus, rxProtByteOne, rxProtByteTwo, v, w;
  logic [7:0] rxSyncStatus, errInsDone, txOctetIn, txOctetOut, errInsReq;
  logic [7:0] expQ[$];
  int failures, checks, n[4];
  wire logic [13:0][7:0] ctlOut;
  localparam logic [13:0][6:0] ctlAddr = {7'h3b, 7'h09, 7'h6e, 7'h11, 7'h10, 7'h0e, 7'h0d, 7'h0c, 7'h0b, 7'h0a,
    7'h08, 7'h04, 7'h01, 7'h00};
  ////////////////////////////////////////////////////////////////////////////////
  aspsr_host_model i_host (.mclk, .regCs, .regRd, .regWr, .regAddr, .regWdata);
  aspsr_regs i_dut (.mclk, .arst_n, .regCs, .regRd, .regWr, .regAddr, .regWdata, .regRdata, .secStatus,
    .lineStatus(8'h00), .pathStatus(8'h00), .txCellStatus(8'h00), .rxCellStatus, .protStatus, .rxProtByteOne,
    .rxProtByteTwo, .rxProtValid, .rxSyncStatus, .rxPathLabel(8'h00), .rxPathStatusByte(8'h00), .oneSecTick,
    .secParityErr, .lineParityErr, .pathParityErr, .hecCorrected, .errInsDone, .txOctetIn, .insertNow,
    .txOctetOut, .errInsReq, .generalCtl(ctlOut[0]), .loopbackCtl(ctlOut[1]), .cellGenCtl(ctlOut[2]),
    .cellValidCtl(ctlOut[3]), .cellBusCtlOne(ctlOut[4]), .cellBusCtlTwo(ctlOut[5]), .txSecCtl(ctlOut[6]),
    .txLineCtl(ctlOut[7]), .txPathCtl(ctlOut[8]), .txProtOne(ctlOut[9]), .txProtTwo(ctlOut[10]),
    .lineFailOutEn(ctlOut[11]), .protThreshold(ctlOut[12]), .pathThreshold(ctlOut[13]), .interruptOutN);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    expQ.push_back(e);
    i_host.acc(1'b0, a, 8'h00);
  endtask : rd
  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // read data compared on the falling edge after the read is taken
  always @(posedge mclk) rdPend <= regCs & regRd;
  always @(negedge mclk) if (rdPend === 1'b1) check(regRdata, expQ.pop_front());
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #200000;
    failures++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, rxProtValid, oneSecTick, insertNow, secParityErr, lineParityErr, pathParityErr, hecCorrected} = '0;
    {secStatus, rxCellStatus, protStatus, rxProtByteOne, rxProtByteTwo, rxSyncStatus, errInsDone, txOctetIn} = '0;
    void'($urandom(32'h42f5));
    repeat (8) @(negedge mclk);
    arst_n = 1'b1;
    rd(7'h09, 8'h36);
    rd(7'h3b, 8'h46);
    v = 8'($urandom);
    i_host.acc(1'b1, 7'h09, v);
    rd(7'h09, v);
    i_host.acc(1'b1, 7'h3b, ~v);
    rd(7'h3b, ~v);
    secStatus = v;
    i_host.acc(1'b1, 7'h45, 8'hff);
    rd(7'h45, {v[7:2], 2'b11});
    {rxProtByteOne, rxProtByteTwo, rxProtValid} = {v, ~v, 1'b1};
    @(negedge mclk) {rxProtByteOne, rxProtByteTwo, rxProtValid} = {~v, v, 1'b0};
    rd(7'h14, v);
    rd(7'h15, ~v);
    $display("registers done");
    w = 8'($urandom);
    i_host.acc(1'b1, 7'h07, w);
    @(negedge mclk) {insertNow, txOctetIn} = {1'b1, v};
    @(negedge mclk) check(txOctetOut, v ^ w);
    insertNow = 1'b0;
    fork
      i_host.acc(1'b1, 7'h06, 8'h03);
      @(negedge mclk) errInsDone = 8'h01;
    join
    check(errInsReq, 8'h02);
    errInsDone = 8'h02;
    @(negedge mclk) errInsDone = 8'h00;
    check(errInsReq, 8'h00);
    $display("insertion done");
    for (int i = 0; i < 600; i++) begin
      @(negedge mclk) v = 8'($urandom);
      {secParityErr, lineParityErr, pathParityErr, hecCorrected} = {v[0], v[1], v[2], v[7:3] == 5'h00};
      for (int k = 0; k < 3; k++) n[k] += v[k];
      n[3] += (v[7:3] == 5'h00);
    end
    @(negedge mclk) {secParityErr, lineParityErr, pathParityErr, hecCorrected} = 4'h0;
    rd(7'h54, 8'(n[0]));
    rd(7'h55, 8'(n[0] >> 8));
    rd(7'h50, 8'(n[1]));
    rd(7'h51, 8'(n[1] >> 8));
    rd(7'h52, 8'(n[1] >> 16));
    rd(7'h56, 8'(n[2]));
    rd(7'h57, 8'(n[2] >> 8));
    rd(7'h4d, 8'(n[3]));
    $display("counters done");
    i_host.acc(1'b1, 7'h00, 8'h30);
    w = 8'($urandom);
    rxCellStatus = w;
    repeat (3) begin
      @(negedge mclk) hecCorrected = 1'b1;
      @(negedge mclk) hecCorrected = 1'b0;
    end
    @(negedge mclk) oneSecTick = 1'b1;
    @(negedge mclk) {oneSecTick, hecCorrected, rxCellStatus} = {2'b01, ~w};
    @(negedge mclk) {hecCorrected, rxCellStatus} = 9'h000;
    rd(7'h49, w);
    rd(7'h4d, 8'(n[3] + 3));
    $display("latch done");
    i_host.acc(1'b1, 7'h00, 8'h40);
    i_host.acc(1'b1, 7'h3a, 8'hff);
    i_host.acc(1'b1, 7'h39, 8'hff);
    i_host.acc(1'b1, 7'h34, 8'h06);
    v = 8'($urandom) | 8'h01;
    protStatus = v;
    repeat (3) @(negedge mclk);
    check(8'(interruptOutN), 8'h00);
    rd(7'h42, v);
    rd(7'h42, 8'h00);
    check(8'(interruptOutN), 8'h01);
    protStatus = 8'h00;
    repeat (3) @(negedge mclk);
    rd(7'h42, v);
    i_host.acc(1'b1, 7'h34, 8'h04);
    rxCellStatus = v;
    repeat (3) @(negedge mclk);
    rxCellStatus = 8'h00;
    repeat (3) @(negedge mclk);
    check(8'(interruptOutN), 8'h01);
    i_host.acc(1'b1, 7'h34, 8'h06);
    repeat (3) @(negedge mclk);
    check(8'(interruptOutN), 8'h00);
    rd(7'h41, v);
    rd(7'h41, 8'h00);
    $display("interrupts done");
    for (int i = 0; i < 14; i++) begin
      v = 8'($urandom);
      if (i == 1) v = 8'h01 << v[2:0];
      i_host.acc(1'b1, ctlAddr[i], v);
      check(ctlOut[i], v);
      rd(ctlAddr[i], v);
    end
    $display("controls done");
    results();
  end
endmodule : testbench
`default_nettype wire
